// ===== fsps_pkg.sv
// Purpose: constants and carrier types of the flash self-program sequencer
// Assumes: 200 MHz system clock, byte-addressed 32-bit register bus
// Notes: flash has 64 pages of 32 words of 16 bits
`default_nettype none
package fsps_pkg;
   localparam int CLK_MHZ = 200;
   // programming time per erase or write, nanoseconds
   localparam int PROG_MIN_NS = 3200000;
   localparam int PROG_MAX_NS = 3400000;
   // least time rounds up, longest rounds down
   localparam int PROG_MIN_CYC = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_MAX_CYC = (PROG_MAX_NS * CLK_MHZ) / 1000;
   localparam int PROG_DEF_CYC = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
   // cycles after the control write in which the store may follow
   localparam logic [2:0] CMD_WINDOW = 3'h4;

   localparam int WORD_BITS = 5;
   localparam int PAGE_BITS = 6;
   localparam int PAGE_WORDS = 32;
   localparam int WORD_LSB = 1;
   localparam int PAGE_LSB = 6;

   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PTR = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hc;

   // command codes of the control register
   localparam logic [7:0] CMD_LOAD = 8'h01;
   localparam logic [7:0] CMD_ERASE = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h05;
   localparam logic [7:0] CMD_REEN = 8'h11;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] WORD_ERASED = 16'hffff;

   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_ARMED = 1;
   localparam int ST_EEBLK = 2;
   localparam int ST_ERASING = 3;

   typedef enum logic [1:0] {FSPS_IDLE, FSPS_ERASE, FSPS_WRITE} fsps_mode_t;

   typedef struct packed {
      logic erase_start;
      logic write_start;
      logic [PAGE_BITS-1:0] page;
   } fsps_flash_req_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } fsps_avm_req_t;
endpackage : fsps_pkg
`default_nettype wire

// ===== fsps_sequencer.sv
// Purpose: flash self-program sequencer: page buffer, erase, page write
// Assumes: core pulses spm_exec for each store-program-memory instruction
// Notes: registers on Avalon-MM, one wait state on every access
`default_nettype none
module fsps_sequencer #(
   parameter int PROG_CYCLES = fsps_pkg::PROG_DEF_CYC
) (
   // system
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire fsps_pkg::fsps_avm_req_t avm_req,
   output logic avm_waitrequest,
   output logic [31:0] avm_readdata,
   // processor core
   input wire logic spm_exec,
   output logic core_stall,
   // data eeprom
   input wire logic eeprom_busy,
   input wire logic eeprom_write_start,
   // flash array
   output fsps_pkg::fsps_flash_req_t flash_req,
   output logic [fsps_pkg::PAGE_WORDS-1:0][15:0] flash_page_data,
   output logic flash_busy
);
   typedef struct packed {
      fsps_pkg::fsps_mode_t mode;
      logic [7:0] ctrl;
      logic [2:0] window;
      logic [15:0] ptr;
      logic [15:0] data;
      logic [31:0] timer;
      logic [fsps_pkg::PAGE_WORDS-1:0][15:0] pbuf;
      logic ack;
      logic [31:0] rdata;
      fsps_pkg::fsps_flash_req_t freq;
   } fsps_state_t;

   fsps_state_t s;
   fsps_state_t next_s;

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic [fsps_pkg::PAGE_WORDS-1:0][15:0] erased_buf();
      logic [fsps_pkg::PAGE_WORDS-1:0][15:0] b;
      for (int i = 0; i < fsps_pkg::PAGE_WORDS; i++) begin
         b[i] = fsps_pkg::WORD_ERASED;
      end
      return b;
   endfunction

   logic [fsps_pkg::WORD_BITS-1:0] word_in_page_field;
   logic [fsps_pkg::PAGE_BITS-1:0] page_select_field;
   logic bus_req;
   logic [31:0] prog_last;

   assign word_in_page_field =
      s.ptr[fsps_pkg::WORD_LSB +: fsps_pkg::WORD_BITS];
   assign page_select_field =
      s.ptr[fsps_pkg::PAGE_LSB +: fsps_pkg::PAGE_BITS];
   assign bus_req = avm_req.read | avm_req.write;
   assign prog_last = 32'(PROG_CYCLES - 1);

   always_comb begin
      next_s = s;
      next_s.freq.erase_start = 1'b0;
      next_s.freq.write_start = 1'b0;

      // bus: every access answered in the cycle after it is raised
      next_s.ack = bus_req & ~s.ack;
      if (bus_req && !s.ack) begin
         case (avm_req.address)
            fsps_pkg::OFS_CTRL: next_s.rdata = {24'h00_0000, s.ctrl};
            fsps_pkg::OFS_PTR: next_s.rdata = {16'h0000, s.ptr};
            fsps_pkg::OFS_DATA: next_s.rdata = {16'h0000, s.data};
            fsps_pkg::OFS_STAT: begin
               next_s.rdata = 32'h0000_0000;
               next_s.rdata[fsps_pkg::ST_BUSY] = s.mode != fsps_pkg::FSPS_IDLE;
               next_s.rdata[fsps_pkg::ST_ARMED] = s.window != 3'h0;
               next_s.rdata[fsps_pkg::ST_EEBLK] = eeprom_busy;
               next_s.rdata[fsps_pkg::ST_ERASING] =
                  s.mode == fsps_pkg::FSPS_ERASE;
            end
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      // the command window counts down; unused command is dropped
      if (s.window != 3'h0) begin
         next_s.window = s.window - 3'h1;
         if (s.window == 3'h1 && s.mode == fsps_pkg::FSPS_IDLE) begin
            next_s.ctrl = fsps_pkg::CTRL_RST;
         end
      end

      if (bus_req && s.ack && avm_req.write) begin
         case (avm_req.address)
            fsps_pkg::OFS_PTR:
               next_s.ptr = merge16(s.ptr, avm_req.writedata,
                                    avm_req.byteenable);
            fsps_pkg::OFS_DATA:
               next_s.data = merge16(s.data, avm_req.writedata,
                                     avm_req.byteenable);
            fsps_pkg::OFS_CTRL: begin
               // an eeprom write in progress locks out every command
               if (avm_req.byteenable[0] && !eeprom_busy &&
                   s.mode == fsps_pkg::FSPS_IDLE) begin
                  if (avm_req.writedata[7:0] == fsps_pkg::CMD_REEN) begin
                     next_s.pbuf = erased_buf();
                     next_s.ctrl = fsps_pkg::CTRL_RST;
                     next_s.window = 3'h0;
                  end else begin
                     next_s.ctrl = avm_req.writedata[7:0];
                     next_s.window = fsps_pkg::CMD_WINDOW;
                  end
               end
            end
            default: ;
         endcase
      end

      // the store instruction, taken only while a command is armed
      if (spm_exec && s.window != 3'h0 && s.mode == fsps_pkg::FSPS_IDLE &&
          !eeprom_busy) begin
         next_s.window = 3'h0;
         next_s.ctrl = fsps_pkg::CTRL_RST;
         case (s.ctrl)
            fsps_pkg::CMD_LOAD: begin
               // any word slot, any order; a repeat overwrites
               next_s.pbuf[word_in_page_field] = s.data;
            end
            fsps_pkg::CMD_ERASE: begin
               next_s.mode = fsps_pkg::FSPS_ERASE;
               next_s.timer = 32'h0000_0000;
               next_s.freq.erase_start = 1'b1;
               next_s.freq.page = page_select_field;
               next_s.ctrl = s.ctrl; // held until the erase ends
            end
            fsps_pkg::CMD_WRITE: begin
               next_s.mode = fsps_pkg::FSPS_WRITE;
               next_s.timer = 32'h0000_0000;
               next_s.freq.write_start = 1'b1;
               next_s.freq.page = page_select_field;
               next_s.ctrl = s.ctrl;
            end
            default: ;
         endcase
      end

      // long operations: timed, then command bits clear and core released
      case (s.mode)
         fsps_pkg::FSPS_IDLE: ;
         fsps_pkg::FSPS_ERASE,
         fsps_pkg::FSPS_WRITE: begin
            next_s.timer = s.timer + 32'h0000_0001;
            if (s.timer == prog_last) begin
               if (s.mode == fsps_pkg::FSPS_WRITE) begin
                  next_s.pbuf = erased_buf();
               end
               next_s.mode = fsps_pkg::FSPS_IDLE;
               next_s.ctrl = fsps_pkg::CTRL_RST;
            end
         end
         default: next_s.mode = fsps_pkg::FSPS_IDLE;
      endcase

      // eeprom write loses whatever has been loaded; the page being
      // written is protected only once the mode is FSPS_WRITE: a start in the same cycle as the store still wipes it
      if (eeprom_write_start && s.mode != fsps_pkg::FSPS_WRITE) begin
         next_s.pbuf = erased_buf();
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s.mode <= fsps_pkg::FSPS_IDLE;
         s.ctrl <= fsps_pkg::CTRL_RST;
         s.window <= 3'h0;
         s.ptr <= 16'h0000;
         s.data <= 16'h0000;
         s.timer <= 32'h0000_0000;
         s.pbuf <= {fsps_pkg::PAGE_WORDS{fsps_pkg::WORD_ERASED}};
         s.ack <= 1'b0;
         s.rdata <= 32'h0000_0000;
         s.freq <= '0;
      end else begin
         s <= next_s;
      end
   end

   // core waits while the array is busy
   assign core_stall = s.mode != fsps_pkg::FSPS_IDLE;
   assign avm_waitrequest = bus_req & ~s.ack;
   assign avm_readdata = s.rdata;
   assign flash_req = s.freq;
   assign flash_page_data = s.pbuf;
   assign flash_busy = core_stall;
endmodule // fsps_sequencer
`default_nettype wire

// ===== fsps_props.sv
// Purpose: port checker of fsps_sequencer
// Assumes: one clock, nrst async low
// Notes: bound into every sequencer instance
`default_nettype none
module fsps_props #(
   parameter int PROG_CYCLES = 20
) (
   // system
   input wire logic clk,
   input wire logic nrst,
   // watched ports
   input wire logic spm_exec,
   input wire logic core_stall,
   input wire logic eeprom_busy,
   input wire logic eeprom_write_start,
   input wire fsps_pkg::fsps_flash_req_t flash_req,
   input wire logic [fsps_pkg::PAGE_WORDS-1:0][15:0] flash_page_data,
   input wire logic flash_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int run;
   logic wr_op;
   wire logic start = flash_req.erase_start | flash_req.write_start;
   // stall length counted here: repetition of PROG_CYCLES (660000 by default) would be too slow
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run <= 0;
         wr_op <= 1'b0;
      end else begin
         run <= core_stall ? run + 1 : 0;
         wr_op <= start ? flash_req.write_start : wr_op;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_stall_len: assert property (
      $fell(core_stall) |-> run == PROG_CYCLES) else $error("stall length");
   chk_stall_start: assert property (
      $rose(core_stall) |-> start) else $error("stall without start");
   chk_start_cause: assert property (
      start |-> $past(spm_exec)) else $error("start without store");
   chk_busy_start: assert property (
      start |-> core_stall && flash_busy) else $error("busy late");
   chk_ee_block: assert property (
      $rose(core_stall) |-> !$past(eeprom_busy)) else $error("ee block");
   chk_write_wipe: assert property (
      $fell(core_stall) && wr_op |-> &flash_page_data) else $error("wipe");
   chk_ee_discard: assert property (
      eeprom_write_start && !core_stall |=> &flash_page_data)
      else $error("ee discard");
   chk_page_hold: assert property (
      core_stall && !start |-> $stable(flash_req.page)) else $error("page");
   cov_erase: cover property (flash_req.erase_start);
   cov_write: cover property (flash_req.write_start);
   cov_ee: cover property (eeprom_write_start);
endmodule // fsps_props
bind fsps_sequencer fsps_props #(.PROG_CYCLES(PROG_CYCLES)) u_fsps_props(
   .clk(clk), .nrst(nrst), .spm_exec(spm_exec), .core_stall(core_stall),
   .eeprom_busy(eeprom_busy), .eeprom_write_start(eeprom_write_start),
   .flash_req(flash_req), .flash_page_data(flash_page_data),
   .flash_busy(flash_busy));
`default_nettype wire

// ===== fsps_core_model.sv
// Purpose: core model issuing store instructions
// Assumes: go marks the control write ack edge
// Notes: a large dly puts the store outside the window
`default_nettype none
module fsps_core_model (
   // system
   input wire logic clk,
   input wire logic nrst,
   // command side
   input wire logic go,
   input wire logic [2:0] dly,
   input wire logic core_stall,
   // store pulse
   output logic spm_exec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic arm;
   logic [2:0] cnt;
   // one store per command, dly+2 cycles after go, once the core is not stalled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arm <= 1'b0;
         cnt <= 3'h0;
         spm_exec <= 1'b0;
      end else begin
         spm_exec <= 1'b0;
         if (go) begin
            arm <= 1'b1;
            cnt <= dly;
         end else if (arm && cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
         end else if (arm && !core_stall) begin
            arm <= 1'b0;
            spm_exec <= 1'b1;
         end
      end
   end
endmodule // fsps_core_model
`default_nettype wire

// ===== test_flash_self_program_sequencer.sv
// Purpose: bench of fsps_sequencer
// Assumes: programming time shortened to 20 cycles
// Notes: each buffer word loaded once per clear
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
   fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_flash_self_program_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 20;
   logic clk = 0, nrst = 0, spm_exec, core_stall, ee_busy = 0, ee_wr = 0;
   logic go = 0, avm_waitrequest, flash_busy;
   logic [2:0] dly = 0;
   logic [31:0] avm_readdata, rdata;
   logic [fsps_pkg::PAGE_WORDS-1:0][15:0] flash_page_data;
   fsps_pkg::fsps_avm_req_t avm_req = '0;
   fsps_pkg::fsps_flash_req_t flash_req;
   int fail_count = 0, tests_run = 0, n;
   fsps_sequencer #(.PROG_CYCLES(PC)) u_fsps_sequencer(.clk(clk),
      .nrst(nrst), .avm_req(avm_req), .avm_waitrequest(avm_waitrequest),
      .avm_readdata(avm_readdata), .spm_exec(spm_exec),
      .core_stall(core_stall), .eeprom_busy(ee_busy),
      .eeprom_write_start(ee_wr), .flash_req(flash_req),
      .flash_page_data(flash_page_data), .flash_busy(flash_busy));
   fsps_core_model u_fsps_core_model(.clk(clk), .nrst(nrst), .go(go),
      .dly(dly), .core_stall(core_stall), .spm_exec(spm_exec));
   initial forever #2.5 clk = ~clk;
   // stall cycles counted apart from the tasks, so none is missed
   always @(posedge clk) begin
      if (core_stall === 1'b1) n++;
   end
   task automatic acc(input logic [3:0] a, input logic w, logic [31:0] d);
      @(posedge clk);
      avm_req <= '{a, !w, w, d, 4'hf};
      do @(posedge clk); while (avm_waitrequest !== 1'b0);
      rdata = avm_readdata;
      avm_req <= '0;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [2:0] d);
      acc(fsps_pkg::OFS_CTRL, 1, 32'(c));
      go <= 1'b1;
      dly <= d;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic load(input logic [4:0] w, logic [15:0] d, logic [2:0] t);
      acc(fsps_pkg::OFS_PTR, 1, 32'({w, 1'b0}));
      acc(fsps_pkg::OFS_DATA, 1, 32'(d));
      cmd(fsps_pkg::CMD_LOAD, t);
   endtask
   task automatic op(input logic [7:0] c, logic [5:0] pg, int e,
                     logic [31:0] st);
      n = 0;
      acc(fsps_pkg::OFS_PTR, 1, 32'({pg, 6'h00}));
      cmd(c, 3'h0);
      acc(fsps_pkg::OFS_STAT, 0, 32'h0000_0000);
      `CHK("status", st, rdata)
      `CHK("flash busy", e != 0, flash_busy)
      while (core_stall === 1'b1) @(posedge clk);
      `CHK("stall cycles", e, n)
      `CHK("page", pg, flash_req.page)
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      `CHK("reset buffer", '1, &flash_page_data)
      load(5'h05, 16'h1234, 3'h1);
      load(5'h02, 16'habcd, 3'h0);
      `CHK("word 5", 16'h1234, flash_page_data[5])
      `CHK("word 2", 16'habcd, flash_page_data[2])
      acc(fsps_pkg::OFS_CTRL, 0, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0000, rdata)
      op(fsps_pkg::CMD_ERASE, 6'h07, PC, 32'h0000_0009);
      `CHK("kept", 16'h1234, flash_page_data[5])
      load(5'h09, 16'h5555, 3'h0);
      `CHK("word 9", 16'h5555, flash_page_data[9])
      op(fsps_pkg::CMD_WRITE, 6'h07, PC, 32'h0000_0001);
      `CHK("wiped", '1, &flash_page_data)
      // store lands one cycle after the window has closed
      load(5'h03, 16'h7777, 3'h2);
      acc(fsps_pkg::OFS_CTRL, 0, 32'h0000_0000);
      `CHK("dropped ctrl", 32'h0000_0000, rdata)
      `CHK("late store", 16'hffff, flash_page_data[3])
      load(5'h03, 16'h7777, 3'h0);
      `CHK("word 3", 16'h7777, flash_page_data[3])
      ee_wr <= 1'b1;
      @(posedge clk);
      ee_wr <= 1'b0;
      @(posedge clk);
      `CHK("ee discard", '1, &flash_page_data)
      load(5'h04, 16'h4444, 3'h0);
      `CHK("word 4", 16'h4444, flash_page_data[4])
      cmd(fsps_pkg::CMD_REEN, 3'h0);
      `CHK("reenable", '1, &flash_page_data)
      ee_busy <= 1'b1;
      op(fsps_pkg::CMD_ERASE, 6'h07, 0, 32'h0000_0004);
      ee_busy <= 1'b0;
      acc(4'h2, 0, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rdata)
      load(5'h06, 16'h6666, 3'h0);
      `CHK("word 6", 16'h6666, flash_page_data[6])
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      `CHK("reset wipe", '1, &flash_page_data)
      acc(fsps_pkg::OFS_PTR, 0, 32'h0000_0000);
      `CHK("reset ptr", 32'h0000_0000, rdata)
      finish_test;
   end
endmodule // test_flash_self_program_sequencer
`default_nettype wire
